// ### tb/tpl_probe_latch_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.vh"
module tpl_probe_latch_chk #(
    parameter POS_W = 32
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [17:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              input_terminal_seven,
    input wire logic              input_terminal_eight,
    input wire logic              enc_index,
    input wire logic [POS_W-1:0]  position,
    input wire logic              irq
);
    // ==========================================================
    // shadow of control and mask, rebuilt from bus writes
    // ==========================================================
    logic [15:0] ctrl_q;
    logic [3:0]  mask_q;
    wire acc    = psel && penable && pready;
    wire a_ctrl = paddr == 18'({`TPL_IDX_CTRL, 2'b00});
    wire a_stat = paddr == 18'({`TPL_IDX_STAT, 2'b00});
    wire a_mask = paddr == 18'({`TPL_IDX_IRQ_MASK, 2'b00});
    wire wr_mask = acc && pwrite && a_mask;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 16'h0000;
            mask_q <= 4'h0;
        end else if (acc && pwrite) begin
            if (a_ctrl && pstrb[0]) ctrl_q[7:0] <= pwdata[7:0] & 8'h37;
            if (a_ctrl && pstrb[1]) ctrl_q[15:8] <= pwdata[15:8] & 8'h37;
            if (a_mask && pstrb[0]) mask_q <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // assertions
    // ==========================================================
    chk_ctrl_readback: assert property (
        acc && !pwrite && a_ctrl |-> prdata == {16'h0000, ctrl_q})
        else $error("control read differs from last write");
    chk_enable_status: assert property (
        acc && !pwrite && a_stat |-> prdata[0] == ctrl_q[0] && prdata[8] == ctrl_q[8])
        else $error("status enable bits differ from control");
    chk_done_cleared: assert property (
        acc && !pwrite && a_stat && !ctrl_q[0] && !$past(ctrl_q[0]) && !$past(ctrl_q[0], 2)
        |-> prdata[2:1] == 2'b00)
        else $error("ch1 done bits kept while disabled");
    chk_no_capture: assert property (
        !ctrl_q[0] && !ctrl_q[8] && $past(!ctrl_q[0] && !ctrl_q[8]) && !$past(wr_mask)
        |-> !$rose(irq))
        else $error("event raised with both channels disabled");
    chk_mask_off: assert property (
        mask_q == 4'h0 |-> !irq)
        else $error("irq high with all events masked");
    chk_ch1_fall: assert property (
        ctrl_q[0] && ctrl_q[1] && ctrl_q[2] && ctrl_q[5] && mask_q[1] && $fell(enc_index)
        |=> irq)
        else $error("ch1 falling index edge not captured");
    chk_ch2_rise: assert property (
        ctrl_q[8] && ctrl_q[9] && !ctrl_q[10] && ctrl_q[12] && mask_q[2]
        && $rose(input_terminal_eight) |=> irq)
        else $error("ch2 rising terminal edge not captured");
    chk_err_unmapped: assert property (
        psel && !penable && paddr == 18'h00000 |=> pslverr [*2] ##1 ($past(psel) || !pslverr))
        else $error("unmapped access not refused");
endmodule
bind tpl_probe_latch tpl_probe_latch_chk #(.POS_W(POS_W)) tpl_probe_latch_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_terminal_seven(input_terminal_seven),
    .input_terminal_eight(input_terminal_eight), .enc_index(enc_index),
    .position(position), .irq(irq));
`default_nettype wire

// ### tb/tpl_probe_latch_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.vh"
module tpl_probe_latch_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, t7, t8, zi, er;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, pos, r, p, q;
    logic [3:0]  pstrb;
    int num_errors = 0;
    int check_count = 0;
    tpl_probe_latch tpl_probe_latch_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_terminal_seven(t7),
        .input_terminal_eight(t8), .enc_index(zi), .position(pos), .irq(irq));
    tpl_src_model tpl_src_model_i (.pclk(pclk), .presetn(presetn),
        .input_terminal_seven(t7), .input_terminal_eight(t8), .enc_index(zi), .position(pos));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ==========================================================
    // bus and compare tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 18'({i, 2'b00});
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle, so no two calls touch psel in one time step
        @(posedge pclk);
    endtask
    task automatic rd(input logic [15:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h00000000);
        chk($sformatf("reg %h", i), e, r);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge pclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge pclk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_regs;
        rd(`TPL_IDX_CTRL, 32'h00000000);
        rd(`TPL_IDX_STAT, 32'h00000000);
        for (int i = 0; i < 4; i++) rd(16'(`TPL_IDX_P1_RISE + i), 32'h00000000);
        apb(1'b1, `TPL_IDX_CTRL, 32'hFFFFFFFF);
        rd(`TPL_IDX_CTRL, 32'h00003737);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00000000);
        apb(1'b1, `TPL_IDX_P1_RISE, 32'hFFFFFFFF);
        rd(`TPL_IDX_P1_RISE, 32'h00000000);
        apb(1'b0, 16'h0000, 32'h00000000);
        chk("unmapped error", 32'h00000001, {31'h0, er});
        $display("test registers done");
    endtask
    task automatic t_single;
        apb(1'b1, `TPL_IDX_IRQ_MASK, 32'h0000000F);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00000011);
        tpl_src_model_i.drive(0, 1'b1, p);
        chk_irq(1'b1);
        rd(`TPL_IDX_P1_RISE, p);
        rd(`TPL_IDX_STAT, 32'h00000003);
        tpl_src_model_i.drive(0, 1'b0, q);
        tpl_src_model_i.drive(0, 1'b1, q);
        rd(`TPL_IDX_P1_RISE, p);
        apb(1'b1, `TPL_IDX_IRQ_STAT, 32'h0000000F);
        chk_irq(1'b0);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00000000);
        rd(`TPL_IDX_STAT, 32'h00000000);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00000011);
        tpl_src_model_i.drive(0, 1'b0, q);
        tpl_src_model_i.drive(0, 1'b1, p);
        rd(`TPL_IDX_P1_RISE, p);
        $display("test single shot done");
    endtask
    task automatic t_cont;
        apb(1'b1, `TPL_IDX_IRQ_MASK, 32'h00000002);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00000037);
        tpl_src_model_i.drive(0, 1'b0, q);
        rd(`TPL_IDX_P1_FALL, 32'h00000000);
        tpl_src_model_i.drive(2, 1'b1, p);
        chk_irq(1'b0);
        rd(`TPL_IDX_P1_RISE, p);
        tpl_src_model_i.drive(2, 1'b0, q);
        chk_irq(1'b1);
        rd(`TPL_IDX_P1_FALL, q);
        tpl_src_model_i.drive(2, 1'b1, p);
        rd(`TPL_IDX_P1_RISE, p);
        rd(`TPL_IDX_STAT, 32'h00000007);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00000036);
        tpl_src_model_i.drive(2, 1'b0, r);
        rd(`TPL_IDX_P1_FALL, q);
        rd(`TPL_IDX_STAT, 32'h00000000);
        $display("test continuous done");
    endtask
    task automatic t_ch2;
        apb(1'b1, `TPL_IDX_CTRL, 32'h00003300);
        apb(1'b1, `TPL_IDX_IRQ_MASK, 32'h00000004);
        chk_irq(1'b0);
        tpl_src_model_i.drive(1, 1'b1, p);
        chk_irq(1'b1);
        rd(`TPL_IDX_P2_RISE, p);
        tpl_src_model_i.drive(1, 1'b0, q);
        rd(`TPL_IDX_P2_FALL, q);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00003100);
        tpl_src_model_i.drive(1, 1'b1, r);
        rd(`TPL_IDX_P2_RISE, p);
        rd(`TPL_IDX_STAT, 32'h00000700);
        apb(1'b1, `TPL_IDX_CTRL, 32'h00003700);
        tpl_src_model_i.drive(1, 1'b0, r);
        rd(`TPL_IDX_P2_FALL, q);
        tpl_src_model_i.drive(2, 1'b1, p);
        rd(`TPL_IDX_P2_RISE, p);
        rd(`TPL_IDX_IRQ_STAT, 32'h0000000F);
        rd(`TPL_IDX_IRQ_MASK, 32'h00000004);
        $display("test channel two done");
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_single();
        t_cont();
        t_ch2();
        complete_run();
    end
    initial begin
        #400000;
        num_errors++;
        $display("unexpected watchdog expected end seen hang");
        complete_run();
    end
endmodule
`default_nettype wire

// ### tb/tpl_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpl_src_model (
    input wire logic    pclk,
    input wire logic    presetn,
    output logic        input_terminal_seven,
    output logic        input_terminal_eight,
    output logic        enc_index,
    output logic [31:0] position
);
    // ==========================================================
    // encoder keeps moving, so a late capture shows a wrong value
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) position <= 32'h00000000;
        else position <= position + 32'h00000011;
    end
    initial begin
        input_terminal_seven = 1'b0;
        input_terminal_eight = 1'b0;
        enc_index = 1'b0;
    end
    // change one source, return the position seen at the capture edge
    task automatic drive(input int which, input logic lvl, output logic [31:0] p);
        @(posedge pclk);
        case (which)
            0: input_terminal_seven <= lvl;
            1: input_terminal_eight <= lvl;
            default: enc_index <= lvl;
        endcase
        p = position + 32'h00000011;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### verilog/tpl_defines.vh
`ifndef TPL_DEFINES_VH
`define TPL_DEFINES_VH

// ==========================================================
// register indices, byte address is four times the index
// ==========================================================
`define TPL_IDX_CTRL      16'h60B8
`define TPL_IDX_STAT      16'h60B9
`define TPL_IDX_P1_RISE   16'h60BA
`define TPL_IDX_P1_FALL   16'h60BB
`define TPL_IDX_P2_RISE   16'h60BC
`define TPL_IDX_P2_FALL   16'h60BD
`define TPL_IDX_IRQ_STAT  16'h60C0
`define TPL_IDX_IRQ_MASK  16'h60C1

// ==========================================================
// control fields, channel two sits one stride higher
// ==========================================================
`define TPL_CH_STRIDE     8
`define TPL_CTL_EN        0
`define TPL_CTL_MODE      1
`define TPL_CTL_SEL       2
`define TPL_CTL_RISE      4
`define TPL_CTL_FALL      5
`define TPL_CTRL_WMASK    16'h3737

// ==========================================================
// status fields, same stride
// ==========================================================
`define TPL_ST_EN         0
`define TPL_ST_RDONE      1
`define TPL_ST_FDONE      2

// ==========================================================
// interrupt bits: ch1 rise, ch1 fall, ch2 rise, ch2 fall
// ==========================================================
`define TPL_IRQ_W         4

// ==========================================================
// reset values
// ==========================================================
`define TPL_CTRL_RST      16'h0000
`define TPL_POS_RST       32'h00000000
`define TPL_IRQ_RST       4'h0

`endif

// ### verilog/tpl_probe_latch.v
// Behaviour
// - capture position when the selected source, terminal or index pulse, changes state
// - control bit 0 enables channel one; disabled channel captures nothing
// - control bit 1: 0 captures once after arming, 1 captures every trigger
// - control bit 2 picks channel one source: terminal seven or index pulse
// - control bit 4 enables ch1 rising capture into its rising position register
// - control bit 5 enables ch1 falling capture into its falling position register
// - control bits 8 and 9 enable channel two and pick its mode
// - control bit 10 picks channel two source: terminal eight or index pulse
// - control bits 12 and 13 enable ch2 rising and falling captures
// - status bit 0 shows ch1 enabled, bit 1 ch1 rising captured
// - status bit 8 ch2 enabled, bits 9 and 10 ch2 captures done
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.vh"

module tpl_probe_latch #(
    parameter POS_W = 32
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [17:0]       paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg  [31:0]       prdata,
    output wire              pready,
    output reg               pslverr,
    input  wire              input_terminal_seven,
    input  wire              input_terminal_eight,
    input  wire              enc_index,
    input  wire [POS_W-1:0]  position,
    output wire              irq
);

    // ==========================================================
    // address decode
    // ==========================================================
    localparam [3:0] SEL_CTRL  = 4'h0;
    localparam [3:0] SEL_STAT  = 4'h1;
    localparam [3:0] SEL_P1R   = 4'h2;
    localparam [3:0] SEL_P1F   = 4'h3;
    localparam [3:0] SEL_P2R   = 4'h4;
    localparam [3:0] SEL_P2F   = 4'h5;
    localparam [3:0] SEL_IST   = 4'h6;
    localparam [3:0] SEL_IMSK  = 4'h7;
    localparam [3:0] SEL_NONE  = 4'hF;

    // misaligned addresses count as unmapped
    function [3:0] tpl_dec;
        input [17:0] a;
        begin
            if (a[1:0] != 2'h0) begin
                tpl_dec = SEL_NONE;
            end else begin
                case (a[17:2])
                    `TPL_IDX_CTRL:     tpl_dec = SEL_CTRL;
                    `TPL_IDX_STAT:     tpl_dec = SEL_STAT;
                    `TPL_IDX_P1_RISE:  tpl_dec = SEL_P1R;
                    `TPL_IDX_P1_FALL:  tpl_dec = SEL_P1F;
                    `TPL_IDX_P2_RISE:  tpl_dec = SEL_P2R;
                    `TPL_IDX_P2_FALL:  tpl_dec = SEL_P2F;
                    `TPL_IDX_IRQ_STAT: tpl_dec = SEL_IST;
                    `TPL_IDX_IRQ_MASK: tpl_dec = SEL_IMSK;
                    default:           tpl_dec = SEL_NONE;
                endcase
            end
        end
    endfunction

    // one gate for every capture: channel enable, edge kind and the
    // single shot lock, so the two edge kinds can never drift apart
    function tpl_hit;
        input en_i;
        input kind_i;
        input edge_i;
        input cont_i;
        input done_i;
        begin
            tpl_hit = en_i & kind_i & edge_i & (cont_i | ~done_i);
        end
    endfunction

    wire [3:0] sel_code;
    wire       setup_ph;
    wire       wr_acc;

    assign sel_code = tpl_dec(paddr);
    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite;
    // zero wait states: data is prepared in the setup cycle
    assign pready   = 1'b1;

    // ==========================================================
    // control register
    // ==========================================================
    reg  [15:0] ctrl_q;
    reg  [15:0] ctrl_d;
    wire        ctrl_wr;
    // reserved control bits never store a one
    localparam [15:0] CTRL_WMASK = `TPL_CTRL_WMASK;

    assign ctrl_wr = wr_acc & (sel_code == SEL_CTRL);

    always @* begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            if (pstrb[0]) begin
                ctrl_d[7:0] = pwdata[7:0] & CTRL_WMASK[7:0];
            end
            if (pstrb[1]) begin
                ctrl_d[15:8] = pwdata[15:8] & CTRL_WMASK[15:8];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TPL_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ==========================================================
    // raw source history
    // ==========================================================
    // each raw source keeps its own history, so flipping the source
    // select never fakes an edge
    reg  in7_q;
    reg  in8_q;
    reg  idx_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in7_q <= 1'b0;
            in8_q <= 1'b0;
            idx_q <= 1'b0;
        end else begin
            in7_q <= input_terminal_seven;
            in8_q <= input_terminal_eight;
            idx_q <= enc_index;
        end
    end

    wire [1:0] term_now;
    wire [1:0] term_old;

    assign term_now = {input_terminal_eight, input_terminal_seven};
    assign term_old = {in8_q, in7_q};

    // ==========================================================
    // capture channels
    // ==========================================================
    wire [1:0]       ch_en;
    wire [1:0]       rise_done;
    wire [1:0]       fall_done;
    wire [1:0]       cap_rise;
    wire [1:0]       cap_fall;
    wire [POS_W-1:0] pos_rise [0:1];
    wire [POS_W-1:0] pos_fall [0:1];

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_ch
            localparam integer B = c * `TPL_CH_STRIDE;

            reg  [POS_W-1:0] rise_pos_q;
            reg  [POS_W-1:0] fall_pos_q;
            reg              rdone_q;
            reg              fdone_q;
            wire             en;
            wire             cont;
            wire             use_idx;
            wire             src_now;
            wire             src_old;
            wire             edge_up;
            wire             edge_dn;

            assign en      = ctrl_q[B + `TPL_CTL_EN];
            assign cont    = ctrl_q[B + `TPL_CTL_MODE];
            assign use_idx = ctrl_q[B + `TPL_CTL_SEL];
            assign src_now = use_idx ? enc_index : term_now[c];
            assign src_old = use_idx ? idx_q : term_old[c];
            assign edge_up = src_now & ~src_old;
            assign edge_dn = ~src_now & src_old;

            // single shot stops after the first hit per edge kind
            assign cap_rise[c] = tpl_hit(en, ctrl_q[B + `TPL_CTL_RISE], edge_up,
                                         cont, rdone_q);
            assign cap_fall[c] = tpl_hit(en, ctrl_q[B + `TPL_CTL_FALL], edge_dn,
                                         cont, fdone_q);

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rise_pos_q <= `TPL_POS_RST;
                    fall_pos_q <= `TPL_POS_RST;
                end else begin
                    if (cap_rise[c]) begin
                        rise_pos_q <= position;
                    end
                    if (cap_fall[c]) begin
                        fall_pos_q <= position;
                    end
                end
            end

            // done bits live apart from the positions: they clear on
            // disable while the captured values stay readable
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rdone_q <= 1'b0;
                    fdone_q <= 1'b0;
                end else begin
                    // a disabled channel drops its done bits; a capture wins
                    rdone_q <= cap_rise[c] | (rdone_q & en);
                    fdone_q <= cap_fall[c] | (fdone_q & en);
                end
            end

            assign ch_en[c]     = en;
            assign rise_done[c] = rdone_q;
            assign fall_done[c] = fdone_q;
            assign pos_rise[c]  = rise_pos_q;
            assign pos_fall[c]  = fall_pos_q;
        end
    endgenerate

    // ==========================================================
    // status word
    // ==========================================================
    reg [15:0] stat_w;

    always @* begin
        stat_w = 16'h0000;
        stat_w[`TPL_ST_EN]                     = ch_en[0];
        stat_w[`TPL_ST_RDONE]                  = rise_done[0];
        stat_w[`TPL_ST_FDONE]                  = fall_done[0];
        stat_w[`TPL_CH_STRIDE + `TPL_ST_EN]    = ch_en[1];
        stat_w[`TPL_CH_STRIDE + `TPL_ST_RDONE] = rise_done[1];
        stat_w[`TPL_CH_STRIDE + `TPL_ST_FDONE] = fall_done[1];
    end

    // ==========================================================
    // interrupt status and mask
    // ==========================================================
    reg  [`TPL_IRQ_W-1:0] irq_st_q;
    reg  [`TPL_IRQ_W-1:0] irq_msk_q;
    wire [`TPL_IRQ_W-1:0] irq_ev;
    wire [`TPL_IRQ_W-1:0] irq_clr;
    wire                  ist_wr;
    wire                  imsk_wr;

    assign irq_ev  = {cap_fall[1], cap_rise[1], cap_fall[0], cap_rise[0]};
    assign ist_wr  = wr_acc & (sel_code == SEL_IST) & pstrb[0];
    assign imsk_wr = wr_acc & (sel_code == SEL_IMSK) & pstrb[0];
    assign irq_clr = ist_wr ? pwdata[`TPL_IRQ_W-1:0] : `TPL_IRQ_RST;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= `TPL_IRQ_RST;
        end else begin
            // a capture in the clearing cycle stays pending
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_msk_q <= `TPL_IRQ_RST;
        end else if (imsk_wr) begin
            irq_msk_q <= pwdata[`TPL_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_st_q & irq_msk_q);

    // ==========================================================
    // read path
    // ==========================================================
    reg [31:0] rd_d;

    always @* begin
        rd_d = 32'h00000000;
        case (sel_code)
            SEL_CTRL: begin
                rd_d[15:0] = ctrl_q;
            end
            SEL_STAT: begin
                rd_d[15:0] = stat_w;
            end
            SEL_P1R: begin
                rd_d[POS_W-1:0] = pos_rise[0];
            end
            SEL_P1F: begin
                rd_d[POS_W-1:0] = pos_fall[0];
            end
            SEL_P2R: begin
                rd_d[POS_W-1:0] = pos_rise[1];
            end
            SEL_P2F: begin
                rd_d[POS_W-1:0] = pos_fall[1];
            end
            SEL_IST: begin
                rd_d[`TPL_IRQ_W-1:0] = irq_st_q;
            end
            SEL_IMSK: begin
                rd_d[`TPL_IRQ_W-1:0] = irq_msk_q;
            end
            default: begin
                rd_d = 32'h00000000;
            end
        endcase
    end

    // read data is frozen at setup, so a capture during the access
    // phase shows up on the next read, never as a torn word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph) begin
            prdata <= pwrite ? 32'h00000000 : rd_d;
        end else if (!psel) begin
            prdata <= 32'h00000000;
        end
    end

    // a write to an unmapped word is flagged as well, and simply dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= (sel_code == SEL_NONE);
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

endmodule

`default_nettype wire
